// >>> flash_host_consts.vh
// Constants for the parallel flash host controller: register map, commands, timing
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH
// ****************************************
// APB register offsets (byte addresses)
// ****************************************
`define REG_CTRL 12'h000
`define REG_ADDR 12'h004
`define REG_DATA 12'h008
`define REG_STAT 12'h00C
`define REG_RDATA 12'h010
`define REG_BUF 12'h014
// ****************************************
// Control register fields
// ****************************************
`define CTRL_GO_BIT 0
`define CTRL_OP_LSB 1
`define CTRL_OP_MSB 4
`define CTRL_PWR_BIT 8
`define CTRL_CNT_LSB 16
`define CTRL_CNT_MSB 23
`define CTRL_RESET 32'h0000_0000
// ****************************************
// Host operations
// ****************************************
`define OP_READ_ARRAY 4'h0
`define OP_READ_ID 4'h1
`define OP_READ_CSR 4'h2
`define OP_CLEAR_SR 4'h3
`define OP_WRITE 4'h4
`define OP_ERASE 4'h5
`define OP_SUSPEND 4'h6
`define OP_READ_XSR 4'h7
`define OP_SWAP 4'h8
`define OP_READ_PB 4'h9
`define OP_LOAD_PB 4'hA
`define OP_SEQ_LOAD 4'hB
`define OP_PB_TO_ARRAY 4'hC
`define OP_TWO_BYTE 4'hD
`define OP_EXT2 4'hE
`define OP_EXT1 4'hF
// ****************************************
// Device commands
// ****************************************
`define CMD_READ_ARRAY 8'hFF
`define CMD_READ_ID 8'h90
`define CMD_READ_CSR 8'h70
`define CMD_CLEAR_SR 8'h50
`define CMD_WRITE 8'h40
`define CMD_ERASE 8'h20
`define CMD_SUSPEND 8'hB0
`define CMD_CONFIRM 8'hD0
`define CMD_READ_XSR 8'h71
`define CMD_SWAP 8'h72
`define CMD_READ_PB 8'h75
`define CMD_LOAD_PB 8'h74
`define CMD_SEQ_LOAD 8'hE0
`define CMD_PB_TO_ARRAY 8'h0C
`define CMD_TWO_BYTE 8'hFB
// ****************************************
// Bus timing (ns) and derived cycles
// ****************************************
`define CLK_PERIOD_NS 25
`define T_ACCESS_NS 150
`define T_STROBE_NS 60
`define ACC_CYCLES ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_CYCLES ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUF_DEPTH 256
`endif

// >>> stage_ram.v
// Staging memory holding page-buffer bytes for sequential loads
`timescale 1ns/100ps
module stage_ram #(
    parameter WIDTH = 8,
    parameter DEPTH = 256,
    parameter AW = 8
) (
    input wire pclk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    // Registered read keeps the data path timing clean
    always @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // stage_ram

// >>> flash_host.v
// Host controller driving a byte-wide parallel flash through its bus pins
`timescale 1ns/100ps
`include "flash_host_consts.vh"
module flash_host #(
    parameter AW = 21,
    parameter ACC = `ACC_CYCLES,
    parameter WRC = `WR_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg power_down_n,
    output reg chip_select_lo_n,
    output reg chip_select_hi_n,
    output reg oe_n,
    output reg we_n,
    output reg byte_mode_n,
    output reg [AW-1:0] flash_addr,
    output reg [7:0] dq_out,
    output reg dq_oe,
    input wire [7:0] dq_in,
    input wire done_flag_n
);
    // ****************************************
    // Registers and state
    // ****************************************
    localparam S_IDLE = 3'd0;
    localparam S_SETUP = 3'd1;
    localparam S_WSTROBE = 3'd2;
    localparam S_WEND = 3'd3;
    localparam S_RSTROBE = 3'd4;
    localparam S_REND = 3'd5;
    localparam S_NEXT = 3'd6;
    reg [31:0] ctrl_reg;
    reg [AW-1:0] addr_reg;
    reg [15:0] data_reg;
    reg [7:0] rdata_reg;
    reg busy_reg;
    reg [2:0] state_reg;
    reg [3:0] step_reg;
    reg [7:0] buf_wdata;
    reg [7:0] idx_reg;
    reg [3:0] tmr_reg;
    reg cyc_wr;
    reg [AW-1:0] cyc_addr;
    reg [7:0] cyc_data;
    reg last_cyc;
    reg buf_wr;
    reg [7:0] buf_waddr;
    wire [7:0] buf_rdata;
    wire [3:0] op = ctrl_reg[`CTRL_OP_MSB:`CTRL_OP_LSB];
    wire [7:0] cnt_cfg = ctrl_reg[`CTRL_CNT_MSB:`CTRL_CNT_LSB];
    wire apb_wr = psel & penable & pwrite;
    wire apb_rd = psel & ~penable & ~pwrite;
    wire hit = (paddr == `REG_CTRL) | (paddr == `REG_ADDR) | (paddr == `REG_DATA) |
        (paddr == `REG_STAT) | (paddr == `REG_RDATA) | (paddr == `REG_BUF);
    // Read is one clock late, so fetch the next byte while the current cycle closes
    wire [7:0] rd_idx = ((state_reg == S_NEXT) && (step_reg >= 4'd3)) ? idx_reg + 8'h01 : idx_reg;
    // Page buffer staging memory for sequential loads
    stage_ram #(.WIDTH(8), .DEPTH(`BUF_DEPTH), .AW(8)) u_stage (
        .pclk(pclk),
        .wr_en(buf_wr),
        .wr_addr(buf_waddr),
        .wr_data(buf_wdata),
        .rd_addr(rd_idx),
        .rd_data(buf_rdata)
    );
    // Command byte of an operation's first cycle
    function [7:0] first_cmd;
        input [3:0] o;
        input [7:0] ext;
        begin
            case (o)
                `OP_READ_ARRAY: first_cmd = `CMD_READ_ARRAY;
                `OP_READ_ID: first_cmd = `CMD_READ_ID;
                `OP_READ_CSR: first_cmd = `CMD_READ_CSR;
                `OP_CLEAR_SR: first_cmd = `CMD_CLEAR_SR;
                `OP_WRITE: first_cmd = `CMD_WRITE;
                `OP_ERASE: first_cmd = `CMD_ERASE;
                `OP_SUSPEND: first_cmd = `CMD_SUSPEND;
                `OP_READ_XSR: first_cmd = `CMD_READ_XSR;
                `OP_SWAP: first_cmd = `CMD_SWAP;
                `OP_READ_PB: first_cmd = `CMD_READ_PB;
                `OP_LOAD_PB: first_cmd = `CMD_LOAD_PB;
                `OP_SEQ_LOAD: first_cmd = `CMD_SEQ_LOAD;
                `OP_PB_TO_ARRAY: first_cmd = `CMD_PB_TO_ARRAY;
                `OP_TWO_BYTE: first_cmd = `CMD_TWO_BYTE;
                default: first_cmd = ext;
            endcase
        end
    endfunction
    // ****************************************
    // APB slave
    // ****************************************
    // No wait state; writes land at the access edge and are dropped while busy; unmapped addresses give an error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `CTRL_RESET;
            addr_reg <= {AW{1'b0}};
            data_reg <= 16'h0000;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            buf_wr <= 1'b0;
            buf_waddr <= 8'h00;
            buf_wdata <= 8'h00;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            buf_wr <= 1'b0;
            if (apb_wr & pready & ~busy_reg) begin
                case (paddr)
                    `REG_CTRL: ctrl_reg <= pwdata;
                    `REG_ADDR: addr_reg <= pwdata[AW-1:0];
                    `REG_DATA: data_reg <= pwdata[15:0];
                    `REG_BUF: begin
                        buf_wr <= 1'b1;
                        buf_waddr <= pwdata[15:8];
                        buf_wdata <= pwdata[7:0];
                    end
                    default: ;
                endcase
            end else if (ctrl_reg[`CTRL_GO_BIT] & (busy_reg | ~ctrl_reg[`CTRL_PWR_BIT])) begin
                ctrl_reg[`CTRL_GO_BIT] <= 1'b0;
            end
            if (apb_rd) begin
                case (paddr)
                    `REG_CTRL: prdata <= ctrl_reg;
                    `REG_ADDR: prdata <= {{(32-AW){1'b0}}, addr_reg};
                    `REG_DATA: prdata <= {16'h0000, data_reg};
                    `REG_STAT: prdata <= {30'h0, ~done_flag_n, busy_reg};
                    `REG_RDATA: prdata <= {24'h000000, rdata_reg};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    // ****************************************
    // Sequence planner: what the current cycle does
    // ****************************************
    // Byte select bit flips for the second byte of a pair
    always @* begin
        cyc_wr = 1'b1;
        cyc_addr = {AW{1'b0}};
        cyc_data = first_cmd(op, data_reg[15:8]);
        last_cyc = 1'b0;
        if (step_reg != 4'd0) begin
            case (op)
                `OP_READ_ARRAY, `OP_READ_ID, `OP_READ_CSR, `OP_READ_XSR, `OP_READ_PB: begin
                    cyc_wr = 1'b0;
                    cyc_addr = addr_reg;
                    last_cyc = 1'b1;
                end
                `OP_WRITE, `OP_LOAD_PB: begin
                    cyc_addr = addr_reg;
                    cyc_data = data_reg[7:0];
                    last_cyc = 1'b1;
                end
                `OP_ERASE, `OP_SUSPEND, `OP_EXT2: begin
                    cyc_addr = addr_reg;
                    cyc_data = (op == `OP_EXT2) ? data_reg[7:0] : `CMD_CONFIRM;
                    last_cyc = 1'b1;
                end
                `OP_TWO_BYTE: begin
                    cyc_addr = {addr_reg[AW-1:1], addr_reg[0] ^ (step_reg == 4'd2)};
                    cyc_data = (addr_reg[0] ^ (step_reg == 4'd2)) ? data_reg[15:8] :
                        data_reg[7:0];
                    last_cyc = (step_reg == 4'd2);
                end
                `OP_PB_TO_ARRAY: begin
                    cyc_addr = (step_reg == 4'd1) ? {{(AW-1){1'b0}}, addr_reg[0]} : addr_reg;
                    cyc_data = ((step_reg == 4'd1) ^ addr_reg[0]) ? cnt_cfg : 8'h00;
                    last_cyc = (step_reg == 4'd2);
                end
                `OP_SEQ_LOAD: begin
                    if (step_reg == 4'd1) begin
                        cyc_data = cnt_cfg;
                    end else if (step_reg == 4'd2) begin
                        cyc_data = 8'h00;
                    end else begin
                        cyc_addr = addr_reg + {{(AW-8){1'b0}}, idx_reg};
                        cyc_data = buf_rdata;
                        last_cyc = (idx_reg == cnt_cfg);
                    end
                end
                default: last_cyc = 1'b1;
            endcase
        end else begin
            last_cyc = (op == `OP_CLEAR_SR) | (op == `OP_SWAP) | (op == `OP_EXT1);
        end
    end
    // ****************************************
    // Bus cycle engine
    // ****************************************
    // Write data is held past the strobe's rising edge so the device latches it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            busy_reg <= 1'b0;
            step_reg <= 4'd0;
            idx_reg <= 8'h00;
            tmr_reg <= 4'd0;
            rdata_reg <= 8'h00;
            power_down_n <= 1'b0;
            chip_select_lo_n <= 1'b1;
            chip_select_hi_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            byte_mode_n <= 1'b0;
            flash_addr <= {AW{1'b0}};
            dq_out <= 8'h00;
            dq_oe <= 1'b0;
        end else begin
            power_down_n <= ctrl_reg[`CTRL_PWR_BIT];
            byte_mode_n <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    chip_select_lo_n <= 1'b1;
                    chip_select_hi_n <= 1'b1;
                    if (ctrl_reg[`CTRL_GO_BIT] & ~busy_reg & ctrl_reg[`CTRL_PWR_BIT]) begin
                        busy_reg <= 1'b1;
                        step_reg <= 4'd0;
                        idx_reg <= 8'h00;
                        state_reg <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    chip_select_lo_n <= 1'b0;
                    chip_select_hi_n <= 1'b0;
                    flash_addr <= cyc_addr;
                    dq_out <= cyc_data;
                    dq_oe <= cyc_wr;
                    tmr_reg <= 4'd0;
                    state_reg <= cyc_wr ? S_WSTROBE : S_RSTROBE;
                end
                S_WSTROBE: begin
                    we_n <= 1'b0;
                    tmr_reg <= tmr_reg + 4'd1;
                    if (tmr_reg == WRC[3:0]) begin
                        we_n <= 1'b1;
                        state_reg <= S_WEND;
                    end
                end
                S_WEND: begin
                    dq_oe <= 1'b0;
                    state_reg <= S_NEXT;
                end
                S_RSTROBE: begin
                    oe_n <= 1'b0;
                    tmr_reg <= tmr_reg + 4'd1;
                    if (tmr_reg == ACC[3:0]) begin
                        state_reg <= S_REND;
                    end
                end
                S_REND: begin
                    rdata_reg <= dq_in;
                    oe_n <= 1'b1;
                    state_reg <= S_NEXT;
                end
                S_NEXT: begin
                    chip_select_lo_n <= 1'b1;
                    chip_select_hi_n <= 1'b1;
                    if (last_cyc) begin
                        busy_reg <= 1'b0;
                        state_reg <= S_IDLE;
                    end else begin
                        if (step_reg >= 4'd3) begin
                            idx_reg <= idx_reg + 8'h01;
                        end else begin
                            step_reg <= step_reg + 4'd1;
                        end
                        state_reg <= S_SETUP;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
            if (!ctrl_reg[`CTRL_PWR_BIT]) begin
                busy_reg <= 1'b0;
                state_reg <= S_IDLE;
                we_n <= 1'b1;
                oe_n <= 1'b1;
                dq_oe <= 1'b0;
            end
        end
    end
endmodule // flash_host

// >>> flash_host_properties.sv
// Port-level checks for the parallel flash host controller
`timescale 1ns/100ps
`include "flash_host_consts.vh"
module flash_host_properties #(
    parameter AW = 21,
    parameter ACC = `ACC_CYCLES,
    parameter WRC = `WR_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire power_down_n,
    input wire chip_select_lo_n,
    input wire chip_select_hi_n,
    input wire oe_n,
    input wire we_n,
    input wire byte_mode_n,
    input wire [AW-1:0] flash_addr,
    input wire [7:0] dq_out,
    input wire dq_oe
);
    // ****
    // Strobe length counter
    // ****
    reg [7:0] low_reg;
    // Counts cycles a strobe is low; a short strobe would miss access or write time
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            low_reg <= 8'h00;
        else
            low_reg <= (oe_n && we_n) ? 8'h00 : low_reg + 8'h01;
    end
    // ****
    // Properties
    // ****
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_we_rise; $rose(we_n); endsequence
    property p_one_strobe; !(!oe_n && !we_n); endproperty
    property p_we_sel; !we_n |-> dq_oe && !chip_select_lo_n && !chip_select_hi_n; endproperty
    property p_oe_float; !oe_n |-> !dq_oe && !chip_select_lo_n && !chip_select_hi_n; endproperty
    property p_pdn_quiet;
        !power_down_n && $past(!power_down_n) |-> chip_select_lo_n && chip_select_hi_n && we_n;
    endproperty
    property p_x8; !byte_mode_n; endproperty
    property p_we_hold; !we_n |-> $stable(flash_addr) && $stable(dq_out); endproperty
    property p_we_len; s_we_rise |-> low_reg >= WRC; endproperty
    property p_oe_len; $rose(oe_n) |-> low_reg >= ACC; endproperty
    property p_ready; s_setup |=> pready ##1 !pready; endproperty
    property p_err; pslverr |-> pready; endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
    a_we_sel: assert property (p_we_sel) else $error("write strobe unselected");
    a_oe_float: assert property (p_oe_float) else $error("read while driving");
    a_pdn_quiet: assert property (p_pdn_quiet) else $error("bus active in power-down");
    a_x8: assert property (p_x8) else $error("not byte mode");
    a_we_hold: assert property (p_we_hold) else $error("address or data moved");
    a_we_len: assert property (p_we_len) else $error("write strobe short");
    a_oe_len: assert property (p_oe_len) else $error("read strobe short");
    a_ready: assert property (p_ready) else $error("apb answer wrong");
    a_err: assert property (p_err) else $error("error without ready");
endmodule // flash_host_properties
bind flash_host flash_host_properties #(.AW(AW), .ACC(ACC), .WRC(WRC)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .power_down_n(power_down_n), .chip_select_lo_n(chip_select_lo_n),
    .chip_select_hi_n(chip_select_hi_n), .oe_n(oe_n), .we_n(we_n),
    .byte_mode_n(byte_mode_n), .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe));

// >>> flash_dev_model.sv
// Behavioural model of the byte-wide flash device seen by the host
`timescale 1ns/100ps
module flash_dev_model #(
    parameter MFR_CODE = 8'h3C, // Arbitrary value
    parameter DEV_CODE = 8'hC5, // Arbitrary value
    parameter BUSY_NS = 3000,
    parameter VPP_HIGH = 1,
    parameter WP_HIGH = 1
) (
    input wire power_down_n,
    input wire chip_select_lo_n,
    input wire chip_select_hi_n,
    input wire oe_n,
    input wire we_n,
    input wire [20:0] flash_addr,
    input wire [7:0] dq_out,
    output wire [7:0] dq_in,
    output wire done_flag_n
);
    reg [7:0] mode_reg = 8'hFF;
    reg [7:0] pend_reg = 8'h00;
    reg [8:0] skip_reg = 9'h000;
    reg cnt_reg = 1'b0;
    reg busy_reg = 1'b0;
    reg fail_reg = 1'b0;
    reg [7:0] last_reg = 8'h00;
    reg [7:0] rd_val;
    event kick;
    wire sel = power_down_n && !chip_select_lo_n && !chip_select_hi_n;
    wire rd_en = sel && !oe_n && we_n;
    // Read source follows the last mode command
    always @* begin
        case (mode_reg)
            8'h90: rd_val = flash_addr[0] ? DEV_CODE : MFR_CODE;
            8'h70, 8'h71: rd_val = {~busy_reg, 1'b0, fail_reg, 5'h00};
            default: rd_val = ~flash_addr[7:0];
        endcase
    end
    // Released bus shows the inverse so a stale sample cannot pass
    always @(rd_en or rd_val) if (rd_en) last_reg = rd_val;
    assign dq_in = rd_en ? rd_val : ~last_reg;
    assign done_flag_n = (busy_reg && power_down_n) ? 1'b0 : 1'bz;
    // Internal engine busy time after an erase confirm
    always @(kick) begin
        busy_reg = 1'b1;
        #BUSY_NS busy_reg = 1'b0;
    end
    // Deep power-down drops every pending sequence
    always @(negedge power_down_n) begin
        mode_reg = 8'hFF;
        pend_reg = 8'h00;
        skip_reg = 9'h000;
    end
    // Commands latch at the end of the write strobe
    always @(posedge we_n) begin
        if (sel) begin
            if (skip_reg != 9'h000) begin
                skip_reg = cnt_reg ? {1'b0, dq_out} + 9'd2 : skip_reg - 9'd1;
                cnt_reg = 1'b0;
            end else if (pend_reg != 8'h00) begin
                if (pend_reg == 8'h20 || pend_reg == 8'hA7) begin
                    // Low supply or write protect on locked blocks aborts with an error
                    if (VPP_HIGH && WP_HIGH) -> kick;
                    else fail_reg = 1'b1;
                end
                if (pend_reg == 8'hB0) busy_reg = 1'b0;
                if (pend_reg inside {8'h40, 8'h10, 8'h20, 8'hB0}) mode_reg = 8'h70;
                pend_reg = 8'h00;
            end else begin
                case (dq_out)
                    8'hFF, 8'h90, 8'h70, 8'h71, 8'h75: mode_reg = dq_out;
                    8'h50: fail_reg = 1'b0;
                    8'h72, 8'hF0, 8'h80: ;
                    8'hE0: begin
                        skip_reg = 9'd1;
                        cnt_reg = 1'b1;
                    end
                    8'hFB, 8'h0C: skip_reg = 9'd2;
                    default: pend_reg = dq_out;
                endcase
            end
        end
    end
endmodule // flash_dev_model

// >>> test_flash_host.sv
// Self-checking bench for the parallel flash host controller
`timescale 1ns/100ps
`include "flash_host_consts.vh"
module test_flash_host;
    localparam MFR = 8'h3C;
    localparam DEV = 8'hC5;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0000_0000;
    wire [31:0] prdata;
    wire pready, pslverr, power_down_n, chip_select_lo_n, chip_select_hi_n;
    wire oe_n, we_n, byte_mode_n, dq_oe, done_w;
    wire [20:0] flash_addr;
    wire [7:0] dq_out, dq_in;
    int err_total = 0;
    int compares = 0;
    int log_n = 0;
    int i;
    reg [47:0] log_d;
    reg [20:0] log_a;
    reg [31:0] rv;
    reg rerr;
    reg [15:0] row;
    pullup (done_w);
    always #12.5 pclk = ~pclk;
    flash_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_down_n(power_down_n), .chip_select_lo_n(chip_select_lo_n),
        .chip_select_hi_n(chip_select_hi_n), .oe_n(oe_n), .we_n(we_n),
        .byte_mode_n(byte_mode_n), .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in), .done_flag_n(done_w));
    flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) partner (.power_down_n(power_down_n),
        .chip_select_lo_n(chip_select_lo_n), .chip_select_hi_n(chip_select_hi_n),
        .oe_n(oe_n), .we_n(we_n), .flash_addr(flash_addr), .dq_out(dq_out), .dq_in(dq_in),
        .done_flag_n(done_w));
    // Log each device write as the strobe ends
    always @(posedge we_n) begin
        if (!chip_select_lo_n && !chip_select_hi_n) begin
            log_d = {log_d[39:0], dq_out};
            log_a = flash_addr;
            log_n = log_n + 1;
        end
    end
    task wrap_up;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input [47:0] got, input [47:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; an idle edge first keeps drivers single per step
    task apb(input w, input [11:0] a, input [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 20);
        rv = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk(1, 0);
            wrap_up;
        end
    endtask
    // Start one operation, poll busy, then compare the written bytes
    task run(input [3:0] o, input [20:0] a, input [15:0] d, input [7:0] c, input int n,
        input [47:0] e);
        int k;
        apb(1'b1, `REG_ADDR, {11'h000, a});
        apb(1'b1, `REG_DATA, {16'h0000, d});
        log_d = 48'h0;
        log_n = 0;
        apb(1'b1, `REG_CTRL, {8'h00, c, 7'h00, 1'b1, 3'h0, o, 1'b1});
        k = 0;
        do begin
            apb(1'b0, `REG_STAT, 32'h0);
            k = k + 1;
        end while (rv[0] !== 1'b0 && k < 400);
        chk(rv[0], 0);
        if (rv[0] !== 1'b0)
            wrap_up;
        chk(log_n, n);
        chk(log_d, e);
    endtask
    task t_reset;
        chk({power_down_n, chip_select_lo_n, chip_select_hi_n, oe_n, we_n, dq_oe}, 6'h1E);
        apb(1'b0, `REG_CTRL, 32'h0);
        chk(rv, `CTRL_RESET);
        apb(1'b0, 12'h020, 32'h0);
        chk(rerr, 1);
        $display("reset test done");
    endtask
    task t_read;
        run(`OP_READ_ID, 21'h0, 16'h0, 8'h0, 1, 48'h90);
        apb(1'b0, `REG_RDATA, 32'h0);
        chk(rv[7:0], MFR);
        run(`OP_READ_ID, 21'h1, 16'h0, 8'h0, 1, 48'h90);
        apb(1'b0, `REG_RDATA, 32'h0);
        chk(rv[7:0], DEV);
        // Array read last so its data can be checked after the loop
        for (i = 0; i < 6; i = i + 1) begin
            row = 72'h270_350_771_872_975_0FF >> (60 - 12 * i);
            run(row[11:8], 21'h33, 16'h0, 8'h0, 1, {40'h0, row[7:0]});
        end
        apb(1'b0, `REG_RDATA, 32'h0);
        chk(rv[7:0], 8'hCC);
        $display("read test done");
    endtask
    task t_write;
        run(`OP_WRITE, 21'h12345, 16'h00A5, 8'h0, 2, 48'h40A5);
        chk(log_a, 21'h12345);
        run(`OP_LOAD_PB, 21'h17, 16'h005A, 8'h0, 2, 48'h745A);
        chk(log_a, 21'h17);
        run(`OP_ERASE, 21'h30000, 16'h0, 8'h0, 2, 48'h20D0);
        chk(log_a, 21'h30000);
        apb(1'b0, `REG_STAT, 32'h0);
        chk(rv[1], 1);
        run(`OP_SUSPEND, 21'h0, 16'h0, 8'h0, 2, 48'hB0D0);
        apb(1'b0, `REG_STAT, 32'h0);
        chk(rv[1], 0);
        $display("write test done");
    endtask
    task t_ext;
        for (i = 0; i < 8; i = i + 1) begin
            row = 128'h77D0_97D0_99D0_A7D0_9601_9602_9603_9604 >> (112 - 16 * i);
            run(`OP_EXT2, 21'h0, row, 8'h0, 2, {32'h0, row});
        end
        run(`OP_EXT1, 21'h0, 16'hF000, 8'h0, 1, 48'hF0);
        run(`OP_EXT1, 21'h0, 16'h8000, 8'h0, 1, 48'h80);
        $display("extended test done");
    endtask
    task t_seq;
        run(`OP_TWO_BYTE, 21'h101, 16'hBEEF, 8'h0, 3, 48'hFBBEEF);
        chk(log_a, 21'h100);
        for (i = 0; i < 3; i = i + 1)
            apb(1'b1, `REG_BUF, {16'h0, i[7:0], 8'h60 + i[7:0]});
        run(`OP_SEQ_LOAD, 21'h40, 16'h0, 8'h02, 6, 48'hE00200606162);
        chk(log_a, 21'h42);
        run(`OP_SEQ_LOAD, 21'h40, 16'h0, 8'h00, 4, 48'hE0000060);
        run(`OP_PB_TO_ARRAY, 21'h40, 16'h0, 8'h05, 3, 48'h0C0500);
        $display("sequence test done");
    endtask
    task t_pdn;
        apb(1'b1, `REG_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        chk(power_down_n, 0);
        log_n = 0;
        apb(1'b1, `REG_CTRL, 32'h0000_0009);
        repeat (20) @(posedge pclk);
        chk(log_n, 0);
        chk({chip_select_lo_n, chip_select_hi_n}, 2'b11);
        apb(1'b0, `REG_CTRL, 32'h0);
        chk(rv[0], 0);
        $display("power-down test done");
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_read;
        t_write;
        t_ext;
        t_seq;
        t_pdn;
        wrap_up;
    end
endmodule // test_flash_host
